// ### shared/dct_pkg.sv
`default_nettype none
package dct_pkg;

  // register select codes on the register port
  localparam logic [3:0] SEL_CAH  = 4'h0;
  localparam logic [3:0] SEL_CAL  = 4'h1;
  localparam logic [3:0] SEL_CBH  = 4'h2;
  localparam logic [3:0] SEL_CBL  = 4'h3;
  localparam logic [3:0] SEL_FH   = 4'h4;
  localparam logic [3:0] SEL_FL   = 4'h5;
  localparam logic [3:0] SEL_CTRL = 4'h6;
  localparam logic [3:0] SEL_TRIG = 4'h7;
  localparam logic [3:0] SEL_STAT = 4'h8;
  localparam logic [3:0] SEL_FRC  = 4'h9;

  // trace_control bit positions
  localparam int CTL_ON    = 7;
  localparam int CTL_ARM   = 6;
  localparam int CTL_TAG   = 5;
  localparam int CTL_BRK   = 4;
  localparam int CTL_DIR_A  = 3;
  localparam int CTL_QUAL_A = 2;
  localparam int CTL_DIR_B  = 1;
  localparam int CTL_QUAL_B = 0;

  // trigger_setup_reg layout: bits 5:4 hard-wired to zero
  localparam int         TRIG_BEGIN = 6;
  localparam logic [7:0] TRIG_WMASK = 8'hCF;
  localparam int         FRC_BIT    = 0;

  localparam int         FIFO_DEPTH = 8;
  localparam logic [3:0] COUNT_FULL = 4'h8;
  localparam logic [7:0] ZERO_BYTE  = 8'h00;

  typedef enum logic [3:0] {
    MD_A_ONLY  = 4'h0,
    MD_A_OR_B  = 4'h1,
    MD_A_THEN  = 4'h2,
    MD_EVT_B   = 4'h3,
    MD_A_EVT_B = 4'h4,
    MD_A_DAT   = 4'h5,
    MD_A_NDAT  = 4'h6,
    MD_INSIDE  = 4'h7,
    MD_OUTSIDE = 4'h8
  } dct_mode_t;

  // one cpu bus cycle
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
    logic        rd;
    logic        valid;
    logic        opfetch;
  } dct_cpu_t;

  // one register access; bdm marks a serial background command
  typedef struct packed {
    logic [3:0] sel;
    logic [7:0] wdata;
    logic       rd;
    logic       wr;
    logic       bdm;
  } dct_bus_t;

  typedef struct packed {
    logic [FIFO_DEPTH-1:0][15:0] fifo;
    logic [15:0]                 ca;
    logic [15:0]                 cb;
    logic [15:0]                 last_op;
    logic [7:0]                  ctrl;
    logic [7:0]                  trig;
    logic [7:0]                  rdata;
    logic [3:0]                  cnt;
    logic                        af;
    logic                        bf;
    logic                        a_seen;
    logic                        started;
    logic                        brk;
    logic                        tag;
    logic                        frc;
  } dct_state_t;

  localparam dct_state_t ST_RESET = '0;

endpackage
`default_nettype wire

// ### hw/dct_top.sv
`timescale 1ns/1ps
`default_nettype none
module dct_top (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // cpu bus and security state
  input  wire dct_pkg::dct_cpu_t cpu,
  input  wire logic             secure,
  // register port
  input  wire dct_pkg::dct_bus_t bus,
  output logic [7:0]            rdata_q,
  // break requests and system reset
  output logic                  brk_req_q,
  output logic                  brk_tag_q,
  output logic                  mcu_reset_q
);

  dct_pkg::dct_state_t s_q;
  dct_pkg::dct_state_t s_d;
  dct_pkg::dct_mode_t  mode;
  logic                hit_a;
  logic                hit_b;
  logic                armed;
  logic                evt;
  logic                beg;
  logic                trig_hit;
  logic                cap;
  logic [15:0]         cap_word;
  logic                rd_fl;

  // address comparators with optional direction qualification
  assign hit_a = cpu.valid && (cpu.addr == s_q.ca)
    && (!s_q.ctrl[dct_pkg::CTL_QUAL_A] || (cpu.rd == s_q.ctrl[dct_pkg::CTL_DIR_A]));
  assign hit_b = cpu.valid && (cpu.addr == s_q.cb)
    && (!s_q.ctrl[dct_pkg::CTL_QUAL_B] || (cpu.rd == s_q.ctrl[dct_pkg::CTL_DIR_B]));

  assign mode  = dct_pkg::dct_mode_t'(s_q.trig[3:0]);
  assign armed = s_q.ctrl[dct_pkg::CTL_ARM];
  assign evt   = (mode == dct_pkg::MD_EVT_B) || (mode == dct_pkg::MD_A_EVT_B);
  // event-only runs are always begin traces
  assign beg   = evt || s_q.trig[dct_pkg::TRIG_BEGIN];
  assign rd_fl = bus.rd && (bus.sel == dct_pkg::SEL_FL);

  // trigger condition per mode; B low byte doubles as data in data modes
  always_comb begin
    trig_hit = 1'b0;
    unique case (mode)
      dct_pkg::MD_A_ONLY:  trig_hit = hit_a;
      dct_pkg::MD_A_OR_B:  trig_hit = hit_a || hit_b;
      dct_pkg::MD_A_THEN:  trig_hit = s_q.a_seen && hit_b;
      dct_pkg::MD_EVT_B:   trig_hit = hit_b;
      dct_pkg::MD_A_EVT_B: trig_hit = s_q.a_seen && hit_b;
      dct_pkg::MD_A_DAT:   trig_hit = hit_a && (cpu.data == s_q.cb[7:0]);
      dct_pkg::MD_A_NDAT:  trig_hit = hit_a && (cpu.data != s_q.cb[7:0]);
      dct_pkg::MD_INSIDE:  trig_hit = cpu.valid && (cpu.addr >= s_q.ca) && (cpu.addr <= s_q.cb);
      dct_pkg::MD_OUTSIDE: trig_hit = cpu.valid && ((cpu.addr < s_q.ca) || (cpu.addr > s_q.cb));
      default:             trig_hit = 1'b0;
    endcase
  end

  // capture: event-only stores data bytes, other modes store fetch addresses
  always_comb begin
    if (evt) begin
      cap      = armed && trig_hit;
      cap_word = {dct_pkg::ZERO_BYTE, cpu.data};
    end else begin
      cap      = armed && cpu.valid && cpu.opfetch && (!beg || s_q.started || trig_hit);
      cap_word = cpu.addr;
    end
  end

  // next state: run events first, register writes last so software wins
  always_comb begin
    s_d     = s_q;
    s_d.brk = 1'b0;
    s_d.frc = 1'b0;
    if (cpu.valid && cpu.opfetch) begin
      s_d.last_op = cpu.addr;
    end
    if (armed) begin
      if (hit_a) begin
        s_d.af     = 1'b1;
        s_d.a_seen = 1'b1;
      end
      if (hit_b) begin
        s_d.bf = 1'b1;
      end
      if (trig_hit) begin
        s_d.started = 1'b1;
      end
    end
    // new entries shift in at the top; head of the queue is entry 0
    if (cap) begin
      s_d.fifo = {cap_word, s_q.fifo[dct_pkg::FIFO_DEPTH-1:1]};
      if (s_q.cnt != dct_pkg::COUNT_FULL) begin
        s_d.cnt = s_q.cnt + 4'h1;
      end
    end
    // run completion
    if (armed && !beg && trig_hit) begin
      s_d.ctrl[dct_pkg::CTL_ARM] = 1'b0;
      s_d.brk = s_q.ctrl[dct_pkg::CTL_BRK];
      s_d.tag = s_q.ctrl[dct_pkg::CTL_TAG];
    end
    if (armed && beg && cap && (s_q.cnt == dct_pkg::COUNT_FULL - 4'h1)) begin
      s_d.ctrl[dct_pkg::CTL_ARM] = 1'b0;
      s_d.brk = s_q.ctrl[dct_pkg::CTL_BRK];
      s_d.tag = s_q.ctrl[dct_pkg::CTL_TAG];
    end
    // unarmed lower-byte reads advance and feed the profiling address in
    if (rd_fl && !armed) begin
      s_d.fifo = {s_q.last_op, s_q.fifo[dct_pkg::FIFO_DEPTH-1:1]};
    end
    // register writes
    if (bus.wr) begin
      unique case (bus.sel)
        dct_pkg::SEL_CAH: if (!armed) s_d.ca[15:8] = bus.wdata;
        dct_pkg::SEL_CAL: if (!armed) s_d.ca[7:0]  = bus.wdata;
        dct_pkg::SEL_CBH: if (!armed) s_d.cb[15:8] = bus.wdata;
        dct_pkg::SEL_CBL: if (!armed) s_d.cb[7:0]  = bus.wdata;
        dct_pkg::SEL_TRIG: if (!armed) s_d.trig = bus.wdata & dct_pkg::TRIG_WMASK;
        dct_pkg::SEL_CTRL: begin
          s_d.ctrl = bus.wdata;
          s_d.ctrl[dct_pkg::CTL_ON] = bus.wdata[dct_pkg::CTL_ON] && !secure;
          // arming needs the module on; clearing either bit stops a run
          s_d.ctrl[dct_pkg::CTL_ARM] = bus.wdata[dct_pkg::CTL_ARM]
            && s_d.ctrl[dct_pkg::CTL_ON];
          if (s_d.ctrl[dct_pkg::CTL_ARM] && !armed) begin
            s_d.cnt     = 4'h0;
            s_d.af      = 1'b0;
            s_d.bf      = 1'b0;
            s_d.a_seen  = 1'b0;
            s_d.started = 1'b0;
          end
        end
        // only a serial background command may force the reset
        dct_pkg::SEL_FRC: s_d.frc = bus.bdm && bus.wdata[dct_pkg::FRC_BIT];
        default: ; // fifo bytes, status and unused codes ignore writes
      endcase
    end
    // read data, registered one cycle after the strobe
    if (bus.rd) begin
      unique case (bus.sel)
        dct_pkg::SEL_CAH:  s_d.rdata = s_q.ca[15:8];
        dct_pkg::SEL_CAL:  s_d.rdata = s_q.ca[7:0];
        dct_pkg::SEL_CBH:  s_d.rdata = s_q.cb[15:8];
        dct_pkg::SEL_CBL:  s_d.rdata = s_q.cb[7:0];
        dct_pkg::SEL_FH:   s_d.rdata = evt ? dct_pkg::ZERO_BYTE : s_q.fifo[0][15:8];
        dct_pkg::SEL_FL:   s_d.rdata = s_q.fifo[0][7:0];
        dct_pkg::SEL_CTRL: s_d.rdata = s_q.ctrl;
        dct_pkg::SEL_TRIG: s_d.rdata = s_q.trig;
        dct_pkg::SEL_STAT: s_d.rdata = {s_q.af, s_q.bf, armed, 1'b0, s_q.cnt};
        default:           s_d.rdata = dct_pkg::ZERO_BYTE;
      endcase
    end
  end

  // whole state in one register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= dct_pkg::ST_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign rdata_q     = s_q.rdata;
  assign brk_req_q   = s_q.brk;
  assign brk_tag_q   = s_q.tag;
  assign mcu_reset_q = s_q.frc;

  default clocking cb_main @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence s_rd_frc;
    bus.rd && (bus.sel == dct_pkg::SEL_FRC);
  endsequence
  sequence s_rd_fl_idle;
    rd_fl && !armed;
  endsequence
  sequence s_host_frc;
    bus.wr && bus.bdm && (bus.sel == dct_pkg::SEL_FRC) && bus.wdata[dct_pkg::FRC_BIT];
  endsequence

  a_frc_reads_zero: assert property (s_rd_frc |=> rdata_q == 8'h00)
    else $error("forced-reset register read nonzero");
  a_user_frc_ignored: assert property (
    (bus.wr && !bus.bdm && (bus.sel == dct_pkg::SEL_FRC)) |=> !mcu_reset_q)
    else $error("user write forced a reset");
  a_host_frc_fires: assert property (s_host_frc |=> mcu_reset_q ##1 !mcu_reset_q)
    else $error("host reset write did not pulse once");
  a_comp_locked: assert property (
    (armed && bus.wr && (bus.sel == dct_pkg::SEL_CAH)) |=> $stable(s_q.ca))
    else $error("comparator written while armed");
  a_fh_no_shift: assert property (
    (bus.rd && (bus.sel == dct_pkg::SEL_FH) && !armed) |=> $stable(s_q.fifo))
    else $error("upper byte read moved the fifo");
  a_fl_profile: assert property (
    s_rd_fl_idle |=> (s_q.fifo[7] == $past(s_q.last_op)) && (s_q.fifo[0] == $past(s_q.fifo[1])))
    else $error("unarmed lower byte read did not shift in last opcode");
  a_armed_no_adv: assert property ((armed && rd_fl && !cap) |=> $stable(s_q.fifo))
    else $error("armed read advanced the fifo");
  a_secure_hold: assert property (
    (secure && !s_q.ctrl[dct_pkg::CTL_ON]) |=> !s_q.ctrl[dct_pkg::CTL_ON])
    else $error("module enabled while secure");
  a_brk_gated: assert property (!s_q.ctrl[dct_pkg::CTL_BRK] |=> !brk_req_q)
    else $error("break request while breaks disabled");
  a_full_ends_run: assert property (
    (armed && beg && cap && !bus.wr && (s_q.cnt == dct_pkg::COUNT_FULL - 4'h1))
    |=> !armed && (s_q.cnt == dct_pkg::COUNT_FULL))
    else $error("begin trace did not end at full");
  a_ctrl_write: assert property (
    (bus.wr && (bus.sel == dct_pkg::SEL_CTRL)) |=> s_q.ctrl[5:0] == $past(bus.wdata[5:0]))
    else $error("control write not taken");

  // fifo: upper byte blanks in event-only modes, lower byte shows the head, byte writes are ignored, event captures store the data byte
  a_fh_evt_zero: assert property (
    (bus.rd && (bus.sel == dct_pkg::SEL_FH) && evt) |=> rdata_q == dct_pkg::ZERO_BYTE)
    else $error("upper byte nonzero in event-only mode");
  a_fifo_wr_ignored: assert property (
    (bus.wr && !bus.rd && !cap && ((bus.sel == dct_pkg::SEL_FH) || (bus.sel == dct_pkg::SEL_FL)))
    |=> $stable(s_q.fifo))
    else $error("fifo byte write changed the fifo");
  a_fl_reads_head: assert property (
    (bus.rd && (bus.sel == dct_pkg::SEL_FL)) |=> rdata_q == $past(s_q.fifo[0][7:0]))
    else $error("lower byte read did not show the head entry");
  a_evt_store: assert property (
    (armed && evt && trig_hit) |=> s_q.fifo[7] == {dct_pkg::ZERO_BYTE, $past(cpu.data)})
    else $error("event-only capture stored a wrong word");

  // arming and stopping a run; a fresh run starts with an empty count
  a_arm_sets_flag: assert property (
    (bus.wr && (bus.sel == dct_pkg::SEL_CTRL) && bus.wdata[dct_pkg::CTL_ARM]
      && bus.wdata[dct_pkg::CTL_ON] && !secure && !armed) |=> armed && (s_q.cnt == 4'h0))
    else $error("arm write did not start a clean run");
  a_arm_clear_stops: assert property (
    (armed && bus.wr && (bus.sel == dct_pkg::SEL_CTRL) && !bus.wdata[dct_pkg::CTL_ARM]) |=> !armed)
    else $error("clearing arm did not stop the run");
  a_end_stop: assert property (
    (armed && !beg && trig_hit && !bus.wr) |=> !armed)
    else $error("end trace did not stop at trigger");

  // break requests follow the trigger and carry the selected type
  a_end_brk: assert property (
    (armed && !beg && trig_hit && s_q.ctrl[dct_pkg::CTL_BRK]) |=> brk_req_q)
    else $error("end trace trigger gave no break request");
  a_brk_type: assert property (
    brk_req_q |-> brk_tag_q == $past(s_q.ctrl[dct_pkg::CTL_TAG]))
    else $error("break type differs from control bit");
  a_no_trig_high: assert property (
    (armed && (s_q.trig[3:0] > dct_pkg::MD_OUTSIDE)) |=> !brk_req_q)
    else $error("unused mode code raised a break");

  // comparator flags only move on a qualified full-address match
  a_dir_a: assert property (
    (armed && !bus.wr && cpu.valid && (cpu.addr == s_q.ca) && s_q.ctrl[dct_pkg::CTL_QUAL_A]
      && (cpu.rd != s_q.ctrl[dct_pkg::CTL_DIR_A])) |=> s_q.af == $past(s_q.af))
    else $error("comparator A matched the wrong direction");
  a_dir_b: assert property (
    (armed && !bus.wr && cpu.valid && (cpu.addr == s_q.cb) && s_q.ctrl[dct_pkg::CTL_QUAL_B]
      && (cpu.rd != s_q.ctrl[dct_pkg::CTL_DIR_B])) |=> s_q.bf == $past(s_q.bf))
    else $error("comparator B matched the wrong direction");
  a_match_addr: assert property (
    (armed && !bus.wr && !s_q.af && (!cpu.valid || (cpu.addr != s_q.ca))) |=> !s_q.af)
    else $error("comparator A flagged without an address match");

  // count is kept for the host: no decrement on reads, never past full
  a_cnt_no_dec: assert property (
    (!armed && rd_fl && !bus.wr) |=> s_q.cnt == $past(s_q.cnt))
    else $error("valid count moved on a read");
  a_cnt_sat: assert property (s_q.cnt <= dct_pkg::COUNT_FULL)
    else $error("valid count beyond fifo depth");
  a_stat_image: assert property (
    (bus.rd && (bus.sel == dct_pkg::SEL_STAT)) |=> rdata_q[5] == $past(armed))
    else $error("status armed flag differs from arm bit");

endmodule
`default_nettype wire

// ### sim/dct_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// cpu core side: one bus cycle per call
module dct_cpu_model (
  // clock
  input  wire logic              ref_clk,
  // cpu bus toward the block
  output var dct_pkg::dct_cpu_t  cpu
);
  initial cpu = '0;

  // drive just after an edge, hold to the taking edge, then scramble the lines
  // so that a stale address can never produce a false match
  task automatic cycle(input logic [15:0] a, input logic r, input logic f);
    @(posedge ref_clk);
    cpu <= {a, ~a[7:0], r, 1'b1, f};
    @(posedge ref_clk);
    cpu <= {~a, a[7:0], ~r, 1'b0, 1'b0};
    #1;
  endtask

  // one data write cycle with a chosen data byte, for event-only captures
  task automatic data_cycle(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    cpu <= {a, d, 1'b0, 1'b1, 1'b0};
    @(posedge ref_clk);
    cpu <= {~a, ~d, 1'b1, 1'b0, 1'b0};
    #1;
  endtask
endmodule
`default_nettype wire

// ### sim/dct_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dct_top_tb;
  logic              ref_clk     = 1'b0;
  logic              rst         = 1'b1;
  logic              secure      = 1'b0;
  dct_pkg::dct_bus_t bus         = '0;
  dct_pkg::dct_cpu_t cpu;
  logic [7:0]        rdata_q;
  logic              brk_req_q;
  logic              brk_tag_q;
  logic              mcu_reset_q;
  int                fails       = 0;
  int                checks_done = 0;
  logic [7:0]        hi;
  logic [7:0]        lo;
  // rows: select, write data, expected readback
  logic [19:0]       rows [10]   = '{20'h01212, 20'h13434, 20'h25656, 20'h37878,
                                     20'h4AA00, 20'h5BB00, 20'h7FFCF, 20'h8FF00,
                                     20'h90100, 20'h60F0F};
  // rows: trigger mode, cpu address, expected break
  logic [23:0]       mrow [6]    = '{24'h156781, 24'h256780, 24'h512340,
                                     24'h612341, 24'h730001, 24'h830000};

  // 100 MHz clock
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  dct_top i_dut (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .cpu         (cpu),
    .secure      (secure),
    .bus         (bus),
    .rdata_q     (rdata_q),
    .brk_req_q   (brk_req_q),
    .brk_tag_q   (brk_tag_q),
    .mcu_reset_q (mcu_reset_q)
  );

  dct_cpu_model i_cpu (
    .ref_clk (ref_clk),
    .cpu     (cpu)
  );

  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one register access; read data taken once the strobe edge has landed
  task automatic acc(input logic [3:0] s, input logic [7:0] d, input logic w,
                     input logic b, output logic [7:0] v);
    @(posedge ref_clk);
    bus <= {s, d, ~w, w, b};
    @(posedge ref_clk);
    bus <= '0;
    #1;
    v = rdata_q;
  endtask

  task automatic test_done;
    if (fails == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge ref_clk);
    fails++;
    test_done();
  end

  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    // every select reads zero after reset, unmapped ones included
    for (int s = 0; s < 16; s++) begin
      acc(s[3:0], 8'h00, 1'b0, 1'b0, lo);
      chk(lo, 16'h0000);
    end
    // ordinary write then read back
    foreach (rows[i]) begin
      acc(rows[i][19:16], rows[i][15:8], 1'b1, 1'b0, lo);
      chk(mcu_reset_q, 16'h0000);
      acc(rows[i][19:16], 8'h00, 1'b0, 1'b0, lo);
      chk(lo, rows[i][7:0]);
    end
    // a secured part keeps the module off
    @(posedge ref_clk) secure <= 1'b1;
    acc(dct_pkg::SEL_CTRL, 8'h80, 1'b1, 1'b0, lo);
    acc(dct_pkg::SEL_CTRL, 8'h00, 1'b0, 1'b0, lo);
    chk(lo, 16'h0000);
    @(posedge ref_clk) secure <= 1'b0;
    // mode code 15 arms but never triggers; clearing arm ends the run
    acc(dct_pkg::SEL_CTRL, 8'hDC, 1'b1, 1'b0, lo);
    i_cpu.cycle(16'h1234, 1'b1, 1'b0);
    chk(brk_req_q, 16'h0000);
    acc(dct_pkg::SEL_STAT, 8'h00, 1'b0, 1'b0, lo);
    chk(lo & 8'h20, 16'h0020);
    acc(dct_pkg::SEL_CTRL, 8'h80, 1'b1, 1'b0, lo);
    acc(dct_pkg::SEL_STAT, 8'h00, 1'b0, 1'b0, lo);
    chk(lo & 8'h20, 16'h0000);
    // end trace on A only, read cycles qualify, both break types
    acc(dct_pkg::SEL_TRIG, 8'h00, 1'b1, 1'b0, lo);
    for (int t = 0; t < 2; t++) begin
      acc(dct_pkg::SEL_CTRL, {2'b11, t[0], 5'b11100}, 1'b1, 1'b0, lo);
      acc(dct_pkg::SEL_CAH, 8'hFF, 1'b1, 1'b0, lo);
      i_cpu.cycle(16'h1234, 1'b0, 1'b0);
      chk(brk_req_q, 16'h0000);
      i_cpu.cycle(16'h1235, 1'b1, 1'b0);
      chk(brk_req_q, 16'h0000);
      i_cpu.cycle(16'h1234, 1'b1, 1'b0);
      chk({brk_req_q, brk_tag_q}, {14'h0, 1'b1, t[0]});
      acc(dct_pkg::SEL_STAT, 8'h00, 1'b0, 1'b0, lo);
      chk(lo & 8'hA0, 16'h0080);
      acc(dct_pkg::SEL_CAH, 8'h00, 1'b0, 1'b0, lo);
      chk(lo, 16'h0012);
    end
    // profiling: the ninth read returns what the first read stored
    acc(dct_pkg::SEL_CTRL, 8'h80, 1'b1, 1'b0, lo);
    for (int k = 0; k < 10; k++) begin
      i_cpu.cycle(16'hA000 + k[15:0], 1'b1, 1'b1);
      acc(dct_pkg::SEL_FH, 8'h00, 1'b0, 1'b0, hi);
      acc(dct_pkg::SEL_FL, 8'h00, 1'b0, 1'b0, lo);
      if (k >= 8) chk({hi, lo}, 16'hA000 + k[15:0] - 16'h0008);
    end
    // trigger modes 1, 2 and 5 to 8, end trace with breaks on
    foreach (mrow[i]) begin
      acc(dct_pkg::SEL_TRIG, {4'h0, mrow[i][23:20]}, 1'b1, 1'b0, lo);
      acc(dct_pkg::SEL_CTRL, 8'hD0, 1'b1, 1'b0, lo);
      i_cpu.cycle(mrow[i][19:4], 1'b1, 1'b0);
      chk(brk_req_q, {12'h000, mrow[i][3:0]});
      acc(dct_pkg::SEL_CTRL, 8'h80, 1'b1, 1'b0, lo);
    end
    // event-only B: eight data bytes, an armed read midway must not advance
    acc(dct_pkg::SEL_TRIG, 8'h03, 1'b1, 1'b0, lo);
    acc(dct_pkg::SEL_CTRL, 8'hC0, 1'b1, 1'b0, lo);
    for (int j = 0; j < 8; j++) begin
      i_cpu.data_cycle(16'h5678, 8'h30 + j[7:0]);
      if (j == 3) acc(dct_pkg::SEL_FL, 8'h00, 1'b0, 1'b0, lo);
    end
    acc(dct_pkg::SEL_STAT, 8'h00, 1'b0, 1'b0, lo);
    chk(lo, 16'h0048);
    acc(dct_pkg::SEL_FH, 8'h00, 1'b0, 1'b0, hi);
    chk(hi, 16'h0000);
    for (int j = 0; j < 8; j++) begin
      acc(dct_pkg::SEL_FL, 8'h00, 1'b0, 1'b0, lo);
      chk(lo, 16'h0030 + j[15:0]);
    end
    // host forced reset through a background write
    acc(dct_pkg::SEL_FRC, 8'h01, 1'b1, 1'b1, lo);
    chk(mcu_reset_q, 16'h0001);
    test_done();
  end
endmodule
`default_nettype wire
